// File: hdl/input_sync.sv
// three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/100ps
`default_nettype none
module input_sync
	import line_cal_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// asynchronous inputs and their filtered copies
	input  wire logic [SYNC_W-1:0] raw,
	output logic      [SYNC_W-1:0] level
);

	logic [SYNC_W-1:0] stage1;
	logic [SYNC_W-1:0] stage2;
	logic [SYNC_W-1:0] stage3;
	logic [SYNC_W-1:0] next_level;

	// stage1 feeds stage2 only; the agreement test looks at stages two and three
	always_comb
	begin
		next_level = (stage2 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level  <= '0;
		end
		else
		begin
			stage1 <= raw;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= next_level;
		end
	end

endmodule
`default_nettype wire

// File: hdl/irq_bank.sv
// sticky interrupt status with write-one-to-clear, mask register and one level output
`timescale 1ns/100ps
`default_nettype none
module irq_bank
	import line_cal_pkg::*;
(
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// event sources and clears
	input  wire logic [REG_W-1:0] event_set,
	input  wire logic [REG_W-1:0] event_clear,
	// mask write port
	input  wire logic             mask_write,
	input  wire logic [REG_W-1:0] mask_data,
	// state and interrupt
	output logic      [REG_W-1:0] status,
	output logic      [REG_W-1:0] mask,
	output logic                  irq
);

	logic [REG_W-1:0] next_status;
	logic [REG_W-1:0] next_mask;

	genvar i;
	generate
		for (i = 0; i < REG_W; i++)
		begin : g_bit
			// a set arriving with its clear wins so no event is lost
			always_comb
			begin
				next_status[i] = event_set[i] | (status[i] & ~event_clear[i]);
			end
		end
	endgenerate

	always_comb
	begin
		next_mask = mask_write ? mask_data : mask;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status <= IRQ_RESET;
			mask   <= IRQ_RESET;
		end
		else
		begin
			status <= next_status;
			mask   <= next_mask;
		end
	end

	assign irq = |(status & mask);

endmodule
`default_nettype wire

// File: hdl/line_cal_overload_billing_ctrl.sv
// calibration, overload protect and billing tone control register with its Avalon-MM slave
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - control register resets to all zeros.
// - calibration-clear bit set makes the device discard stored calibration data.
// - writing one to manual-calibration bit starts a manual calibration.
// - auto-calibration disable bit suppresses automatic calibration while one.
// - bit four is reserved, its read value must not be relied on.
// - billing-tone enable makes the device watch the line for billing tones.
// - with detection enabled, off-hook is held through a detected billing tone.
// - billing-tone seen flag stays clear while detection is disabled.
// - billing tone sets the seen flag, which stays set until cleared.
// - writing zero to billing-tone enable clears the seen flag.
// - excessive receive level sets the receive overload flag.
// - writing zero to receive overload clears it and its interrupt flag.
module line_cal_overload_billing_ctrl
	import line_cal_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              arst_n,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [DATA_W-1:0] writedata,
	input  wire logic [BE_W-1:0]   byteenable,
	output logic      [DATA_W-1:0] readdata,
	output logic                   waitrequest,
	// detector levels from the analog side, asynchronous
	input  wire logic              billing_tone_present,
	input  wire logic              rx_overload_level,
	// same-clock inputs
	input  wire logic              off_hook_request,
	input  wire logic              calibration_done,
	// controls toward calibration, protection and hook logic
	output analog_ctrl_t           analog_ctrl,
	// interrupt
	output logic                   irq
);

	// word decode used by every register
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_addr);
		addr_hit = (a == reg_addr);
	endfunction

	// reset release
	logic [1:0] rst_pipe;
	logic [1:0] next_rst_pipe;
	logic       rst_n;

	always_comb
	begin
		next_rst_pipe = {rst_pipe[0], 1'b1};
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_pipe <= RST_PIPE_RESET;
		end
		else
		begin
			rst_pipe <= next_rst_pipe;
		end
	end

	assign rst_n = rst_pipe[1];

	// synchronised detector levels
	logic [SYNC_W-1:0] raw_levels;
	logic [SYNC_W-1:0] sync_levels;
	logic              tone_level;
	logic              overload_level;

	assign raw_levels[SYNC_TONE] = billing_tone_present;
	assign raw_levels[SYNC_OVL]  = rx_overload_level;

	input_sync u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.raw   (raw_levels),
		.level (sync_levels)
	);

	assign tone_level     = sync_levels[SYNC_TONE];
	assign overload_level = sync_levels[SYNC_OVL];

	// bus handshake: one wait cycle, then the answer
	bus_state_t        bus_state;
	bus_state_t        next_bus_state;
	logic [DATA_W-1:0] next_readdata;
	logic              request;
	logic              accept;
	logic              write_lane0;
	logic              ctrl_write;
	logic              status_write;
	logic              mask_write;

	logic [REG_W-1:0]  ctrl_word;
	logic [REG_W-1:0]  irq_status;
	logic [REG_W-1:0]  irq_mask;
	logic [REG_W-1:0]  live_word;

	ctrl_t             ctrl;
	ctrl_t             next_ctrl;

	assign request     = read | write;
	assign accept      = request & (bus_state == BUS_ANSWER);
	assign waitrequest = request & (bus_state != BUS_ANSWER);

	// writes take effect only at the edge where waitrequest is seen low
	assign write_lane0  = write & accept & byteenable[0];
	assign ctrl_write   = write_lane0 & addr_hit(address, CTRL_TWO_ADDR);
	assign status_write = write_lane0 & addr_hit(address, IRQ_STATUS_ADDR);
	assign mask_write   = write_lane0 & addr_hit(address, IRQ_MASK_ADDR);

	always_comb
	begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE:
			begin
				if (request)
				begin
					next_bus_state = BUS_ANSWER;
				end
			end
			BUS_ANSWER:
			begin
				next_bus_state = BUS_IDLE;
			end
			default:
			begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	// the reserved bit reads zero here; software must not count on that
	always_comb
	begin
		ctrl_word           = '0;
		ctrl_word[CAL_CLEAR_BIT]    = ctrl.calibration_clear;
		ctrl_word[MAN_CAL_BIT]      = ctrl.manual_calibration_start;
		ctrl_word[AUTO_CAL_OFF_BIT] = ctrl.auto_calibration_disable;
		ctrl_word[RSVD_BIT]         = 1'b0;
		ctrl_word[PROTECT_BIT]      = ctrl.overload_protect_enable;
		ctrl_word[TONE_EN_BIT]      = ctrl.billing_tone_detect_enable;
		ctrl_word[OVERLOAD_BIT]     = ctrl.rx_overload_flag;
		ctrl_word[TONE_SEEN_BIT]    = ctrl.billing_tone_seen_flag;
	end

	always_comb
	begin
		live_word                = '0;
		live_word[LIVE_TONE_BIT] = tone_level;
		live_word[LIVE_OVL_BIT]  = overload_level;
		live_word[LIVE_HOLD_BIT] = analog_ctrl.off_hook_hold;
	end

	// read data is captured in the wait cycle and stands through the answer cycle
	always_comb
	begin
		next_readdata = readdata;
		if (read && bus_state == BUS_IDLE)
		begin
			next_readdata = '0;
			if (addr_hit(address, CTRL_TWO_ADDR))
			begin
				next_readdata[REG_W-1:0] = ctrl_word;
			end
			else if (addr_hit(address, IRQ_STATUS_ADDR))
			begin
				next_readdata[REG_W-1:0] = irq_status;
			end
			else if (addr_hit(address, IRQ_MASK_ADDR))
			begin
				next_readdata[REG_W-1:0] = irq_mask;
			end
			else if (addr_hit(address, LIVE_STATE_ADDR))
			begin
				next_readdata[REG_W-1:0] = live_word;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_state <= BUS_IDLE;
			readdata  <= '0;
		end
		else
		begin
			bus_state <= next_bus_state;
			readdata  <= next_readdata;
		end
	end

	// control register and its hardware-set flags
	logic         tone_flag_rise;
	analog_ctrl_t next_analog_ctrl;

	always_comb
	begin
		next_ctrl = ctrl;
		if (ctrl_write)
		begin
			next_ctrl.calibration_clear          = writedata[CAL_CLEAR_BIT];
			next_ctrl.manual_calibration_start   = writedata[MAN_CAL_BIT];
			next_ctrl.auto_calibration_disable   = writedata[AUTO_CAL_OFF_BIT];
			next_ctrl.overload_protect_enable    = writedata[PROTECT_BIT];
			next_ctrl.billing_tone_detect_enable = writedata[TONE_EN_BIT];
			// only a zero clears; a one written here changes nothing
			if (!writedata[OVERLOAD_BIT])
			begin
				next_ctrl.rx_overload_flag = 1'b0;
			end
		end
		// a live overload wins over a clear in the same cycle
		if (overload_level)
		begin
			next_ctrl.rx_overload_flag = 1'b1;
		end
		// host writes never reach the seen flag; disabling detection clears it
		if (!next_ctrl.billing_tone_detect_enable)
		begin
			next_ctrl.billing_tone_seen_flag = 1'b0;
		end
		else if (tone_level)
		begin
			next_ctrl.billing_tone_seen_flag = 1'b1;
		end
	end

	assign tone_flag_rise = next_ctrl.billing_tone_seen_flag & ~ctrl.billing_tone_seen_flag;

	// outputs toward the analog side
	always_comb
	begin
		next_analog_ctrl.calibration_clear          = next_ctrl.calibration_clear;
		next_analog_ctrl.manual_calibration_pulse   = ctrl_write & writedata[MAN_CAL_BIT];
		next_analog_ctrl.auto_calibration_disable   = next_ctrl.auto_calibration_disable;
		// protection is driven as written; clearing it before off-hook is the host's job
		next_analog_ctrl.overload_protect_enable    = next_ctrl.overload_protect_enable;
		next_analog_ctrl.billing_tone_detect_enable = next_ctrl.billing_tone_detect_enable;
		// a tone on the line would otherwise look like a loop drop, so hold the line
		next_analog_ctrl.off_hook_hold = off_hook_request
			| (ctrl.billing_tone_detect_enable & tone_level);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl        <= ctrl_t'(CTRL_RESET[6:0]);
			analog_ctrl <= '0;
		end
		else
		begin
			ctrl        <= next_ctrl;
			analog_ctrl <= next_analog_ctrl;
		end
	end

	// interrupt events and clears
	logic [REG_W-1:0] irq_events;
	logic [REG_W-1:0] irq_clears;

	always_comb
	begin
		irq_events               = '0;
		irq_events[IRQ_TONE_BIT] = tone_flag_rise;
		irq_events[IRQ_CAL_BIT]  = calibration_done;
		irq_events[IRQ_ROV_BIT]  = overload_level;
	end

	always_comb
	begin
		irq_clears = status_write ? writedata[REG_W-1:0] : '0;
		if (ctrl_write && !writedata[OVERLOAD_BIT])
		begin
			irq_clears[IRQ_ROV_BIT] = 1'b1;
		end
	end

	irq_bank u_irq (
		.clock       (clock),
		.rst_n       (rst_n),
		.event_set   (irq_events),
		.event_clear (irq_clears),
		.mask_write  (mask_write),
		.mask_data   (writedata[REG_W-1:0]),
		.status      (irq_status),
		.mask        (irq_mask),
		.irq         (irq)
	);

endmodule
`default_nettype wire

// File: inc/line_cal_pkg.sv
// shared constants and types for the line-side calibration, overload and billing tone control bank
package line_cal_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;
	localparam int REG_W  = 8;
	localparam int SYNC_W = 2;

	// register index as printed; byte address is four times the index
	localparam logic [5:0]        CTRL_TWO_INDEX  = 6'h11;
	localparam logic [ADDR_W-1:0] CTRL_TWO_ADDR   = {CTRL_TWO_INDEX, 2'b00};
	localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h80;
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 8'h84;
	localparam logic [ADDR_W-1:0] LIVE_STATE_ADDR = 8'h88;

	// control register field positions
	localparam int CAL_CLEAR_BIT    = 7;
	localparam int MAN_CAL_BIT      = 6;
	localparam int AUTO_CAL_OFF_BIT = 5;
	localparam int RSVD_BIT         = 4;
	localparam int PROTECT_BIT      = 3;
	localparam int TONE_EN_BIT      = 2;
	localparam int OVERLOAD_BIT     = 1;
	localparam int TONE_SEEN_BIT    = 0;

	localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

	// interrupt status and mask layout
	localparam int IRQ_TONE_BIT  = 0;
	localparam int IRQ_CAL_BIT   = 2;
	localparam int IRQ_ROV_BIT   = 6;
	localparam logic [REG_W-1:0] IRQ_RESET = 8'h00;

	// live state layout
	localparam int LIVE_TONE_BIT = 0;
	localparam int LIVE_OVL_BIT  = 1;
	localparam int LIVE_HOLD_BIT = 2;

	// synchroniser lanes
	localparam int SYNC_TONE = 0;
	localparam int SYNC_OVL  = 1;

	localparam logic [1:0] RST_PIPE_RESET = 2'b00;

	typedef enum logic [0:0] {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

	typedef struct packed {
		logic calibration_clear;
		logic manual_calibration_start;
		logic auto_calibration_disable;
		logic overload_protect_enable;
		logic billing_tone_detect_enable;
		logic rx_overload_flag;
		logic billing_tone_seen_flag;
	} ctrl_t;

	typedef struct packed {
		logic calibration_clear;
		logic manual_calibration_pulse;
		logic auto_calibration_disable;
		logic overload_protect_enable;
		logic billing_tone_detect_enable;
		logic off_hook_hold;
	} analog_ctrl_t;

endpackage

// File: testbench/analog_side_model.sv
// stand-in for the analog side: detector levels and the calibration engine
`timescale 1ns/100ps
`default_nettype none
module analog_side_model
	import line_cal_pkg::*;
#(
	parameter int CAL_CYCLES = 12
)
(
	// clock
	input  wire logic   clock,
	// scenario commands
	input  wire logic   tone_on,
	input  wire logic   overload_on,
	// controls in, detector levels out
	input  wire analog_ctrl_t analog_ctrl,
	output logic        billing_tone_present,
	output logic        rx_overload_level,
	output logic        calibration_done
);
	int unsigned count;
	// comparator outputs carry no memory of their own
	assign billing_tone_present = tone_on;
	assign rx_overload_level    = overload_on;
	initial
	begin
		count = 0;
		calibration_done = 1'b0;
	end
	// a real calibration takes a while, so the answer is never prompt
	always @(posedge clock)
	begin
		calibration_done <= (count == 1);
		if (analog_ctrl.manual_calibration_pulse)
			count <= CAL_CYCLES;
		else if (count != 0)
			count <= count - 1;
	end
endmodule
`default_nettype wire

// File: testbench/line_cal_assertions.sv
// port assertions for the control register bank
`timescale 1ns/100ps
`default_nettype none
module line_cal_checker
	import line_cal_pkg::*;
(
	// clock and reset
	input wire logic              clock,
	input wire logic              arst_n,
	// register bus
	input wire logic [ADDR_W-1:0] address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [DATA_W-1:0] writedata,
	input wire logic [BE_W-1:0]   byteenable,
	input wire logic              waitrequest,
	// line side
	input wire logic              off_hook_request,
	input wire logic              billing_tone_present,
	input wire analog_ctrl_t      analog_ctrl,
	input wire logic              irq
);
	logic       ctrl_wr;
	logic [2:0] en_bits;
	assign ctrl_wr = write && !waitrequest && address == CTRL_TWO_ADDR && byteenable[0];
	assign en_bits = {writedata[AUTO_CAL_OFF_BIT], writedata[PROTECT_BIT], writedata[TONE_EN_BIT]};
	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("waitrequest longer than one cycle");
	a_reset_zero: assert property ($rose(arst_n) |-> analog_ctrl == '0 && !irq)
		else $error("controls not zero out of reset");
	a_cal_clear_set: assert property (ctrl_wr && writedata[CAL_CLEAR_BIT]
		|=> analog_ctrl.calibration_clear)
		else $error("calibration clear not raised");
	a_cal_clear_drop: assert property (ctrl_wr && !writedata[CAL_CLEAR_BIT]
		|=> !analog_ctrl.calibration_clear)
		else $error("calibration clear not dropped");
	a_man_cal_pulse: assert property (ctrl_wr && writedata[MAN_CAL_BIT] |=> analog_ctrl.manual_calibration_pulse
		##1 !analog_ctrl.manual_calibration_pulse)
		else $error("manual calibration pulse wrong");
	a_man_cal_none: assert property (ctrl_wr && !writedata[MAN_CAL_BIT]
		|=> !analog_ctrl.manual_calibration_pulse)
		else $error("calibration started without request");
	a_enable_bits: assert property (ctrl_wr |=> {analog_ctrl.auto_calibration_disable,
		analog_ctrl.overload_protect_enable, analog_ctrl.billing_tone_detect_enable} == $past(en_bits))
		else $error("enable controls differ from write");
	a_hold_tone: assert property ((billing_tone_present && analog_ctrl.billing_tone_detect_enable)[*6]
		|=> analog_ctrl.off_hook_hold)
		else $error("hook not held through tone");
	a_hold_off: assert property (!off_hook_request && !analog_ctrl.billing_tone_detect_enable
		|=> !analog_ctrl.off_hook_hold)
		else $error("hook held with detection off");
	c_man_cal: cover property (ctrl_wr && writedata[MAN_CAL_BIT]);
	c_tone_hold: cover property (analog_ctrl.off_hook_hold && !off_hook_request);
	c_irq: cover property (irq);
endmodule
bind line_cal_overload_billing_ctrl line_cal_checker chk_i (
	.clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
	.writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
	.off_hook_request(off_hook_request), .billing_tone_present(billing_tone_present),
	.analog_ctrl(analog_ctrl), .irq(irq)
);
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the control register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
	import line_cal_pkg::*;
	logic              clock = 1'b0;
	logic              arst_n = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [DATA_W-1:0] writedata = '0;
	logic [BE_W-1:0]   byteenable = '0;
	logic [DATA_W-1:0] readdata;
	logic              waitrequest;
	logic              tone_on = 1'b0;
	logic              overload_on = 1'b0;
	logic              billing_tone_present;
	logic              rx_overload_level;
	logic              off_hook_request = 1'b0;
	logic              calibration_done;
	analog_ctrl_t      analog_ctrl;
	logic              irq;
	logic [DATA_W-1:0] q;
	int                errors = 0;
	int                n_compared = 0;

	always #2.5 clock = ~clock;

	line_cal_overload_billing_ctrl DUT (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .billing_tone_present(billing_tone_present),
		.rx_overload_level(rx_overload_level), .off_hook_request(off_hook_request),
		.calibration_done(calibration_done), .analog_ctrl(analog_ctrl), .irq(irq));
	analog_side_model M (.clock(clock), .tone_on(tone_on), .overload_on(overload_on), .analog_ctrl(analog_ctrl),
		.billing_tone_present(billing_tone_present), .rx_overload_level(rx_overload_level),
		.calibration_done(calibration_done));

	task automatic report_and_stop();
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [BE_W-1:0] be);
		@(posedge clock);
		address    <= a;
		writedata  <= {24'h000000, d};
		byteenable <= be;
		write      <= wr;
		read       <= !wr;
		// sampled at the rising edge; only the watchdog ends a hung wait
		do
			@(posedge clock);
		while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	// bit 4 of the control register may read either way, so it is masked everywhere
	task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'h1);
		chk(n, {24'h000000, e}, q & 32'hffffffef);
	endtask

	task automatic t_reset();
		rd("ctrl", CTRL_TWO_ADDR, CTRL_RESET);
		rd("status", IRQ_STATUS_ADDR, IRQ_RESET);
		chk("irq", 32'h0, 32'(irq));
	endtask
	task automatic t_ctrl();
		wr(CTRL_TWO_ADDR, 8'hff);
		rd("ctrl ones", CTRL_TWO_ADDR, 8'hec);
		chk("controls", 32'h2e, 32'(analog_ctrl));
		bus(1'b1, CTRL_TWO_ADDR, 8'h00, 4'h0);
		rd("ctrl be0", CTRL_TWO_ADDR, 8'hec);
		wr(CTRL_TWO_ADDR, 8'h00);
		@(posedge clock);
		chk("controls off", 32'h0, 32'(analog_ctrl));
		rd("unmapped", 8'hf0, 8'h00);
	endtask
	task automatic t_cal();
		// the write of all ones above also started a calibration; let it finish and clear it
		repeat (20) @(posedge clock);
		wr(IRQ_STATUS_ADDR, 8'h04);
		rd("cal idle", IRQ_STATUS_ADDR, 8'h00);
		wr(CTRL_TWO_ADDR, 8'h40);
		repeat (20) @(posedge clock);
		rd("cal done", IRQ_STATUS_ADDR, 8'h04);
		wr(IRQ_STATUS_ADDR, 8'h04);
		rd("cal w1c", IRQ_STATUS_ADDR, 8'h00);
		wr(CTRL_TWO_ADDR, 8'h00);
	endtask
	task automatic t_tone();
		tone_on <= 1'b1;
		repeat (10) @(posedge clock);
		rd("tone off", CTRL_TWO_ADDR, 8'h00);
		wr(CTRL_TWO_ADDR, 8'h04);
		repeat (10) @(posedge clock);
		rd("tone seen", CTRL_TWO_ADDR, 8'h05);
		chk("hold", 32'h1, 32'(analog_ctrl.off_hook_hold));
		rd("live", LIVE_STATE_ADDR, 8'h05);
		tone_on <= 1'b0;
		repeat (10) @(posedge clock);
		wr(CTRL_TWO_ADDR, 8'h04);
		rd("tone sticky", CTRL_TWO_ADDR, 8'h05);
		wr(CTRL_TWO_ADDR, 8'h00);
		rd("tone clear", CTRL_TWO_ADDR, 8'h00);
		rd("tone event", IRQ_STATUS_ADDR, 8'h01);
		wr(IRQ_STATUS_ADDR, 8'h01);
	endtask
	task automatic t_ovl();
		wr(IRQ_MASK_ADDR, 8'h40);
		rd("mask", IRQ_MASK_ADDR, 8'h40);
		overload_on <= 1'b1;
		repeat (8) @(posedge clock);
		overload_on <= 1'b0;
		repeat (8) @(posedge clock);
		rd("ovl", CTRL_TWO_ADDR, 8'h02);
		chk("irq on", 32'h1, 32'(irq));
		wr(CTRL_TWO_ADDR, 8'h02);
		rd("ovl kept", CTRL_TWO_ADDR, 8'h02);
		wr(CTRL_TWO_ADDR, 8'h00);
		rd("ovl clear", CTRL_TWO_ADDR, 8'h00);
		rd("ovl irq clear", IRQ_STATUS_ADDR, 8'h00);
		chk("irq off", 32'h0, 32'(irq));
		off_hook_request <= 1'b1;
		repeat (3) @(posedge clock);
		chk("hook", 32'h1, 32'(analog_ctrl.off_hook_hold));
		off_hook_request <= 1'b0;
	endtask

	initial
	begin
		repeat (5000) @(posedge clock);
		errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_ctrl();
		t_cal();
		t_tone();
		t_ovl();
		report_and_stop();
	end
endmodule
`default_nettype wire
